// [core/run_seq_defines.vh]
// Constants for the run sequencing and ramp selection block
`ifndef RUN_SEQ_DEFINES_VH
`define RUN_SEQ_DEFINES_VH
// Clock rate in kHz (20 MHz)
`define CLK_KHZ 20000
// Scan periods in ms
`define SCAN_FAST_MS 2
`define SCAN_SLOW_MS 5
// Scan periods in clock cycles
`define SCAN_FAST_CYC (`SCAN_FAST_MS * `CLK_KHZ)
`define SCAN_SLOW_CYC (`SCAN_SLOW_MS * `CLK_KHZ)
// Run source codes
`define SRC_PANEL 2'h0
`define SRC_TERM 2'h1
`define SRC_XMIT 2'h2
`define SRC_OPT 2'h3
// Reset values of settings
`define RST_RUN_SOURCE 2'h1
`define RST_SCAN_SEL 1'h1
`define RST_INTERLOCK 1'h0
`define RST_TIME_UNIT 1'h1
// Ramp time default, 10.0 s in 0.1 s units
`define RAMP_DEFAULT 17'h00064
// Ramp time limits: 6000.0 s and 600.00 s
`define RAMP_MAX_TENTH 17'h0ea60
`define RAMP_MAX_HUNDR 17'h0ea60
// Ramp time units in ms
`define UNIT_HUNDR_MS 10
`define UNIT_TENTH_MS 100
// Display unit codes
`define DISP_HZ 1'h0
`define DISP_PCT 1'h1
// Full scale percent in 0.01 % units
`define PCT_FULL 17'h02710
`endif

// [core/run_seq_ramp.v]
// Run sequencing, reference selection and speed ramp
// Notes on behaviour
// R1: Display unit change rescales stored presets
// R2: Three step inputs pick presets two-eight
// R3: Jog uses jog reference; terminal jog inputs
// R4: Panel jog needs no input assignment
// R5: Run source from panel, terminals, link, option
// R6: Terminals default to two-wire forward/reverse
// R7: Three-wire mode gives run, stop, direction
// R8: Inputs accepted after two agreeing scans
// R9: Integrator picks 5 ms for contacts
// R10: Interlock 0 needs run off-on after remote
// R11: Interlock 1 follows run level at once
// R12: Ramp unit 0.01 s or 0.1 s
// R13: Accel time is zero to maximum
// R14: Decel time is maximum to zero
// R15: Four time pairs chosen by two selectors
// R16: 0.1 s unit limits to 6000.0 s
// R17: 0.01 s unit limits to 600.00 s
// R18: Display unit Hz or percent of maximum
// R19: Linear ramp, max over time per step
`timescale 1ns/1ps
`include "run_seq_defines.vh"
module run_seq_ramp #(
  parameter FW = 17,
  parameter FMAX_HZ = 17'd40000,
  parameter SCAN_FAST = `SCAN_FAST_CYC,
  parameter SCAN_SLOW = `SCAN_SLOW_CYC
) (
  input wire clk_sys,
  input wire resetn,
  input wire [1:0] runSourceSelect,
  input wire inputDoubleReadSelect,
  input wire remoteSwitchRunInterlock,
  input wire rampTimeUnitSelect,
  input wire displayUnitSelect,
  input wire threeWireMode,
  input wire remoteMode,
  input wire termFwdRun,
  input wire termRevRun,
  input wire [2:0] stepIn,
  input wire jogRefIn,
  input wire fwdJogIn,
  input wire revJogIn,
  input wire [1:0] timeSelIn,
  input wire panelRun,
  input wire panelRev,
  input wire panelJog,
  input wire xmitRun,
  input wire xmitRev,
  input wire optRun,
  input wire optRev,
  input wire presetWrEn,
  input wire [3:0] presetWrIdx,
  input wire [FW-1:0] presetWrData,
  input wire rampWrEn,
  input wire [2:0] rampWrIdx,
  input wire [FW-1:0] rampWrData,
  output reg runOut_ff,
  output reg revOut_ff,
  output reg jogActive_ff,
  output reg [FW-1:0] outFreq_ff,
  output reg [FW-1:0] selRef_ff,
  output reg [1:0] rampPair_ff,
  output reg interlockHold_ff
);
  // Preset table: 0..7 presets, 8 jog, stored in display unit
  reg [FW-1:0] preset_ff [0:8];
  // Ramp times: even index accel, odd decel
  reg [FW-1:0] ramp_ff [0:7];
  reg [31:0] scanCnt_ff; // Scan divider
  reg scanTick_ff; // One-cycle scan enable
  reg dispUnit_ff; // Last display unit seen
  reg remote_ff; // Previous remote mode
  reg lastRun_ff; // Previous selected-source run level (srcRun)
  reg latch3w_ff; // Three-wire run latch
  reg [31:0] stepAcc_ff; // Ramp step accumulator
  wire [9:0] filt; // Filtered terminal inputs
  wire [9:0] rawBus; // Raw terminal inputs, same order
  integer i;

  assign rawBus = {timeSelIn, revJogIn, fwdJogIn, jogRefIn, stepIn,
                   termRevRun, termFwdRun};

  // One filter per terminal input
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : gFilt
      two_scan_filter uFilt (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .scanTick(scanTick_ff),
        .rawIn(rawBus[g]),
        .filtOut(filt[g])
      );
    end
  endgenerate

  wire fRun = filt[0];
  wire fRev = filt[1];
  wire [2:0] fStep = filt[4:2];
  wire fJogRef = filt[5];
  wire fFwdJog = filt[6];
  wire fRevJog = filt[7];
  wire [1:0] fTimeSel = filt[9:8];

  // Scan divider, period by double-read select
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scanCnt_ff <= 32'h0;
      scanTick_ff <= 1'b0;
    end else begin
      scanTick_ff <= 1'b0;
      if (scanCnt_ff >= (inputDoubleReadSelect ? SCAN_SLOW - 1
                                               : SCAN_FAST - 1)) begin
        scanCnt_ff <= 32'h0; // see R8
        scanTick_ff <= 1'b1;
      end else begin
        scanCnt_ff <= scanCnt_ff + 32'h1;
      end
    end
  end

  // Terminal decode: two-wire or three-wire
  reg termRun;
  reg termRev;
  always @* begin
    if (threeWireMode) begin
      termRun = latch3w_ff; // see R7
      termRev = fStep[0]; // Direction input, high for reverse
    end else begin
      termRun = fRun ^ fRev; // see R6
      termRev = fRev & ~fRun;
    end
  end

  // Source selection including jog
  reg srcRun;
  reg srcRev;
  reg srcJog;
  always @* begin
    srcJog = 1'b0;
    case (runSourceSelect)
      `SRC_PANEL: begin
        srcRun = panelRun | panelJog; // see R5
        srcRev = panelRev;
        srcJog = panelJog; // see R4
      end
      `SRC_TERM: begin
        srcJog = fJogRef | fFwdJog | fRevJog; // see R3
        srcRun = termRun | fFwdJog | fRevJog;
        srcRev = fRevJog ? 1'b1 : (fFwdJog ? 1'b0 : termRev);
      end
      `SRC_XMIT: begin
        srcRun = xmitRun;
        srcRev = xmitRev;
      end
      default: begin
        srcRun = optRun;
        srcRev = optRev;
      end
    endcase
  end

  // Preset index from step inputs, jog wins
  wire [3:0] refIdx = srcJog ? 4'h8 : {1'b0, fStep}; // see R2

  // Rescale value between Hz and percent units
  function [FW-1:0] rescale;
    input [FW-1:0] v;
    input toPct;
    reg [33:0] p;
    begin
      p = toPct ? ({17'h0, v} * {17'h0, `PCT_FULL}) / {17'h0, FMAX_HZ}
                : ({17'h0, v} * {17'h0, FMAX_HZ}) / {17'h0, `PCT_FULL};
      rescale = p[FW-1:0];
    end
  endfunction

  // Limit a ramp time to the range of the unit
  function [FW-1:0] clampRamp;
    input [FW-1:0] v;
    input unit;
    begin
      if (unit && v > `RAMP_MAX_TENTH) clampRamp = `RAMP_MAX_TENTH;
      else if (!unit && v > `RAMP_MAX_HUNDR) clampRamp = `RAMP_MAX_HUNDR;
      else clampRamp = v; // see R16 see R17
    end
  endfunction

  // Preset and ramp storage, presets rescale on display unit change
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 9; i = i + 1) preset_ff[i] <= {FW{1'b0}};
      for (i = 0; i < 8; i = i + 1) ramp_ff[i] <= `RAMP_DEFAULT;
      dispUnit_ff <= `DISP_HZ;
    end else begin
      dispUnit_ff <= displayUnitSelect;
      if (dispUnit_ff != displayUnitSelect) begin
        for (i = 0; i < 9; i = i + 1)
          preset_ff[i] <= rescale(preset_ff[i],
                                  displayUnitSelect); // see R1 see R18
      end else if (presetWrEn && presetWrIdx < 4'h9) begin
        preset_ff[presetWrIdx] <= presetWrData;
      end
      if (rampWrEn)
        ramp_ff[rampWrIdx] <= clampRamp(rampWrData, rampTimeUnitSelect);
    end
  end

  // Reference in Hz units for the ramp
  wire [FW-1:0] refRaw = preset_ff[refIdx];
  wire [FW-1:0] refHz = dispUnit_ff ? rescale(refRaw, 1'b0) : refRaw;
  wire [FW-1:0] target = runOut_ff ? refHz : {FW{1'b0}};

  // Active ramp time, converted to ms
  wire accel = target > outFreq_ff; // see R13
  wire [FW-1:0] rampSet = ramp_ff[{rampPair_ff, ~accel}]; // see R14
  wire [31:0] rampMs = {15'h0, rampSet} *
    (rampTimeUnitSelect ? `UNIT_TENTH_MS : `UNIT_HUNDR_MS); // see R12
  wire [31:0] scanMs = inputDoubleReadSelect ? `SCAN_SLOW_MS
                                             : `SCAN_FAST_MS;

  // Run interlock, three-wire latch and outputs
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      remote_ff <= 1'b0;
      lastRun_ff <= 1'b0;
      latch3w_ff <= 1'b0;
      interlockHold_ff <= 1'b0;
      runOut_ff <= 1'b0;
      revOut_ff <= 1'b0;
      jogActive_ff <= 1'b0;
      selRef_ff <= {FW{1'b0}};
      rampPair_ff <= 2'h0;
      outFreq_ff <= {FW{1'b0}};
      stepAcc_ff <= 32'h0;
    end else begin
      remote_ff <= remoteMode;
      lastRun_ff <= srcRun;
      // Three-wire: run sets, open stop clears
      if (!fRev) latch3w_ff <= 1'b0;
      else if (fRun) latch3w_ff <= 1'b1;
      if (remoteMode && !remote_ff)
        interlockHold_ff <= srcRun & ~remoteSwitchRunInterlock; // see R10 see R11
      else if (!srcRun)
        interlockHold_ff <= 1'b0; // see R10
      runOut_ff <= srcRun & ~interlockHold_ff &
                   ~(remoteMode && !remote_ff && !remoteSwitchRunInterlock);
      revOut_ff <= srcRev;
      jogActive_ff <= srcJog;
      selRef_ff <= refRaw;
      rampPair_ff <= fTimeSel; // see R15
      // Linear ramp stepped once per scan
      if (scanTick_ff) begin
        if (rampMs == 32'h0) begin
          outFreq_ff <= target;
          stepAcc_ff <= 32'h0;
        end else if (stepAcc_ff + {15'h0, FMAX_HZ} * scanMs >= rampMs) begin
          stepAcc_ff <= (stepAcc_ff + {15'h0, FMAX_HZ} * scanMs) % rampMs;
          if (accel)
            outFreq_ff <= (target - outFreq_ff <= 17'h1) ? target
                          : outFreq_ff + 17'h1; // see R19
          else if (target < outFreq_ff)
            outFreq_ff <= (outFreq_ff - target <= 17'h1) ? target
                          : outFreq_ff - 17'h1;
        end else begin
          stepAcc_ff <= stepAcc_ff + {15'h0, FMAX_HZ} * scanMs;
        end
      end
    end
  end
endmodule // run_seq_ramp

// [core/two_scan_filter.v]
// Two-scan agreement filter for one control input
`timescale 1ns/1ps
module two_scan_filter (
  input wire clk_sys,
  input wire resetn,
  input wire scanTick,
  input wire rawIn,
  output reg filtOut
);
  reg firstScan_ff; // Value seen on the previous scan

  // Accept a new level only when two scans agree
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      firstScan_ff <= 1'b0;
      filtOut <= 1'b0;
    end else if (scanTick) begin
      firstScan_ff <= rawIn;
      if (firstScan_ff == rawIn) begin
        filtOut <= rawIn; // see R8
      end
    end
  end
endmodule // two_scan_filter

// [test/cmd_sources.sv]
// Model of terminal, panel and link run command sources
`timescale 1ns/1ps
module cmd_sources (
  input wire clk_sys,
  input wire runReq,
  input wire revReq,
  output reg termFwdRun = 1'b0,
  output reg termRevRun = 1'b0,
  output reg panelRun = 1'b0,
  output reg panelRev = 1'b0,
  output reg xmitRun = 1'b0,
  output reg xmitRev = 1'b0,
  output reg optRun = 1'b0
);
  // All sources follow one request; terminals as two-wire pair
  always @(posedge clk_sys) begin
    termFwdRun <= runReq & ~revReq;
    termRevRun <= runReq & revReq;
    panelRun <= runReq;
    panelRev <= revReq;
    xmitRun <= runReq;
    xmitRev <= revReq;
    optRun <= runReq;
  end
endmodule // cmd_sources

// [test/run_seq_ramp_properties.sv]
// Checker on the run sequencing and ramp outputs
`timescale 1ns/1ps
module run_seq_ramp_chk #(
  parameter FW = 17
) (
  input wire clk_sys,
  input wire resetn,
  input wire [1:0] runSourceSelect,
  input wire remoteMode,
  input wire remoteSwitchRunInterlock,
  input wire panelRun,
  input wire panelRev,
  input wire panelJog,
  input wire xmitRun,
  input wire xmitRev,
  input wire optRun,
  input wire runOut_ff,
  input wire revOut_ff,
  input wire jogActive_ff,
  input wire [FW-1:0] outFreq_ff,
  input wire interlockHold_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_panel_run;
    runSourceSelect == 2'h0 && !remoteMode && panelRun && !panelJog
      |=> runOut_ff && revOut_ff == $past(panelRev);
  endproperty
  a_panel_run: assert property (p_panel_run)
    else $error("panel run not followed");
  property p_xmit_run;
    runSourceSelect == 2'h2 && xmitRun |=> runOut_ff && revOut_ff == $past(xmitRev);
  endproperty
  a_xmit_run: assert property (p_xmit_run)
    else $error("link run not followed");
  property p_opt_run;
    runSourceSelect == 2'h3 && optRun |=> runOut_ff;
  endproperty
  a_opt_run: assert property (p_opt_run)
    else $error("option run not followed");
  property p_xmit_off;
    (runSourceSelect == 2'h2 && !xmitRun && !panelJog) [*2] |-> !runOut_ff;
  endproperty
  a_xmit_off: assert property (p_xmit_off)
    else $error("run without link command");
  property p_panel_jog;
    runSourceSelect == 2'h0 && panelJog |=> jogActive_ff;
  endproperty
  a_panel_jog: assert property (p_panel_jog)
    else $error("panel jog not active");
  property p_one_step;
    $changed(outFreq_ff) |-> (outFreq_ff - $past(outFreq_ff)) == 1
      || ($past(outFreq_ff) - outFreq_ff) == 1;
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("output frequency jumped");
  property p_hold_blocks;
    interlockHold_ff |-> !runOut_ff;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks)
    else $error("run while interlocked");
  property p_hold_cause;
    $rose(interlockHold_ff) |-> !$past(remoteSwitchRunInterlock);
  endproperty
  a_hold_cause: assert property (p_hold_cause)
    else $error("interlock with follow setting");
endmodule // run_seq_ramp_chk
bind run_seq_ramp run_seq_ramp_chk #(.FW(FW)) run_seq_ramp_chk_inst (
  .clk_sys, .resetn, .runSourceSelect, .remoteMode,
  .remoteSwitchRunInterlock, .panelRun, .panelRev, .panelJog, .xmitRun,
  .xmitRev, .optRun, .runOut_ff, .revOut_ff, .jogActive_ff, .outFreq_ff,
  .interlockHold_ff);

// [test/tb_top.sv]
// Testbench for run sequencing and ramp selection
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, resetn, runReq = 0, revReq = 0, optRev = 0;
  logic [1:0] runSourceSelect = 0, timeSelIn = 0;
  logic inputDoubleReadSelect = 1;
  logic remoteSwitchRunInterlock = 0, rampTimeUnitSelect = 1;
  logic displayUnitSelect = 0, threeWireMode = 0, remoteMode = 0;
  logic jogRefIn = 0, fwdJogIn = 0, revJogIn = 0, panelJog = 0;
  logic [2:0] stepIn = 0, rampWrIdx = 0;
  logic presetWrEn = 0, rampWrEn = 0;
  logic [3:0] presetWrIdx = 0;
  logic [16:0] presetWrData = 0, rampWrData = 0, outFreq_ff, selRef_ff;
  logic termFwdRun, termRevRun, panelRun, panelRev, xmitRun, xmitRev;
  logic optRun, runOut_ff, revOut_ff, jogActive_ff, interlockHold_ff;
  logic [1:0] rampPair_ff;
  int fails = 0, checked = 0;
  cmd_sources cmd_sources_inst (.clk_sys, .runReq, .revReq, .termFwdRun,
    .termRevRun, .panelRun, .panelRev, .xmitRun, .xmitRev, .optRun);
  run_seq_ramp #(.FMAX_HZ(17'h01770), .SCAN_FAST(4), .SCAN_SLOW(10))
    run_seq_ramp_inst (.*);
  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  task cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk(logic [16:0] seen, logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe into preset or ramp store
  task wr(bit ramp, logic [3:0] idx, logic [16:0] d);
    cyc(1);
    presetWrEn <= !ramp;
    rampWrEn <= ramp;
    presetWrIdx <= idx;
    rampWrIdx <= idx[2:0];
    presetWrData <= d;
    rampWrData <= d;
    cyc(1);
    presetWrEn <= 0;
    rampWrEn <= 0;
  endtask
  task t_sources;
    for (int s = 0; s < 4; s++) begin
      if (s != 1) begin
        runSourceSelect <= 2'(s);
        runReq <= 1;
        revReq <= s[1];
        optRev <= s[1];
        cyc(3);
        chk(runOut_ff, 1);
        chk(revOut_ff, s[1]);
        runReq <= 0;
        cyc(3);
        chk(runOut_ff, 0);
      end
    end
  endtask
  task t_steps;
    for (int i = 0; i < 9; i++) wr(0, 4'(i), 17'(i * 16 + 5));
    runSourceSelect <= 0;
    for (int i = 0; i < 8; i++) begin
      stepIn <= 3'(i);
      cyc(30);
      chk(selRef_ff, 17'(i * 16 + 5));
    end
    panelJog <= 1;
    cyc(3);
    chk(jogActive_ff, 1);
    chk(selRef_ff, 17'h00085);
    panelJog <= 0;
    stepIn <= 0;
  endtask
  task t_pairs;
    for (int t = 0; t < 4; t++) begin
      timeSelIn <= 2'(t);
      cyc(30);
      chk(rampPair_ff, 17'(t));
    end
    timeSelIn <= 0;
  endtask
  task t_interlock;
    runSourceSelect <= 1;
    runReq <= 1;
    cyc(30);
    remoteMode <= 1;
    cyc(30);
    chk(runOut_ff, 0);
    chk(interlockHold_ff, 1);
    runReq <= 0;
    cyc(30);
    runReq <= 1;
    revReq <= 1;
    cyc(30);
    chk(runOut_ff, 1);
    chk(revOut_ff, 1);
    remoteMode <= 0;
    remoteSwitchRunInterlock <= 1;
    cyc(3);
    remoteMode <= 1;
    cyc(3);
    chk(runOut_ff, 1);
    chk(interlockHold_ff, 0);
    runReq <= 0;
    revReq <= 0;
    remoteMode <= 0;
  endtask
  task t_ramp;
    runSourceSelect <= 0;
    wr(0, 0, 17'h00064);
    runReq <= 1;
    cyc(1200);
    chk(outFreq_ff, 17'h00064);
    runReq <= 0;
    cyc(1200);
    chk(outFreq_ff, 0);
    wr(1, 0, 17'h0ea60);
    runReq <= 1;
    cyc(500);
    chk(outFreq_ff, 0);
    runReq <= 0;
    rampTimeUnitSelect <= 0;
    cyc(2);
    runReq <= 1;
    cyc(500);
    chk(outFreq_ff != 0 && outFreq_ff < 100, 1);
    runReq <= 0;
  endtask
  // Unit change rescales stored presets, Hz to percent and back
  task t_units;
    runSourceSelect <= 0;
    stepIn <= 0;
    wr(0, 0, 17'h00bb8);
    displayUnitSelect <= 1;
    cyc(3);
    chk(selRef_ff, 17'h01388);
    displayUnitSelect <= 0;
    cyc(3);
    chk(selRef_ff, 17'h00bb8);
  endtask
  task tally_and_finish;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    resetn = 0;
    cyc(5);
    resetn <= 1;
    t_sources;
    t_steps;
    t_pairs;
    t_interlock;
    t_ramp;
    t_units;
    tally_and_finish;
  end
  // Cut a hang well past the expected run length
  initial begin
    cyc(20000);
    fails++;
    tally_and_finish;
  end
endmodule // tb_top
